// File: core/gpio_flag_pins.sv
// Flag output and general-purpose pin logic for two signal subsystems.
// Assumes board inputs are synchronous to CORE_CLK and a simple
// strobe-based register port with read data one cycle after the strobe.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module gpio_flag_pins
    import gpio_flag_pkg::*;
#(
    parameter int SUBS = SUBSYS_COUNT
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [DATA_W-1:0] RDATA,
    // Board controls
    input wire logic OFF_N,
    input wire logic PORT_MODE_SELECT,
    // Core side inputs per subsystem
    input wire logic [SUBS-1:0] TIMER_OUT,
    input wire logic [SUBS-1:0] IO_SPACE_ACCESS,
    // External flags
    output logic [SUBS-1:0] EXTERNAL_FLAG_OUT,
    output logic [SUBS-1:0] EXTERNAL_FLAG_OE,
    // General-purpose pins, four per subsystem
    input wire logic [4*SUBS-1:0] GPIO_IN,
    output logic [4*SUBS-1:0] GPIO_OUT,
    output logic [4*SUBS-1:0] GPIO_OE,
    // Derived signals toward the core
    output logic [SUBS-1:0] BRANCH_CONDITION_INPUT,
    output logic [SUBS-1:0] ROM_ENABLE_STRAP
);

    // ==========================================================
    // Address decode helper
    // Matches one register word of one subsystem.
    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input int sub,
        input logic [4:0] off
    );
        logic [ADDR_W-1:0] base;
        base = ADDR_W'(sub * SUB_STRIDE);
        return a == (base + ADDR_W'(off));
    endfunction

    // ==========================================================
    // Software state
    logic [SUBS-1:0] flag;
    logic [3:0] dat [SUBS];
    logic [3:0] dir [SUBS];
    logic [SUBS-1:0] timer_sel;
    logic [SUBS-1:0] host_mux;

    // Strap capture state
    logic strap_taken;

    // Next read word
    logic [DATA_W-1:0] next_rdata;

    genvar s;
    generate
        for (s = 0; s < SUBS; s++) begin : g_sub

            // Shared carrier toward the pin multiplexer
            pin_mux_if pm ();

            logic [3:0] level;
            logic [3:0] pin_view;

            // Local slice of the pin bundle
            assign level = GPIO_IN[4*s +: 4];

            // ==================================================
            // Flag register: plain write, set and clear words
            // Set and clear give a one-bit access without a
            // read-modify-write of the whole word.
            always_ff @(posedge CORE_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    flag[s] <= FLAG_RESET;
                end else if (WR_STB && hit(ADDR, s, FLAG_OFFSET)) begin
                    flag[s] <= WDATA[0];
                end else if (WR_STB && hit(ADDR, s, FLAG_SET_OFFSET)) begin
                    if (WDATA[0]) begin
                        flag[s] <= 1'b1;
                    end
                end else if (WR_STB &&
                             hit(ADDR, s, FLAG_CLEAR_OFFSET)) begin
                    if (WDATA[0]) begin
                        flag[s] <= 1'b0;
                    end
                end
            end

            // ==================================================
            // Pin control register
            // Direction resets to input so only the memory-mode pin 3 strobe drives after reset.
            always_ff @(posedge CORE_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    dat[s] <= PIN_DATA_RESET;
                    dir[s] <= PIN_DIR_RESET;
                    timer_sel[s] <= TIMER_SEL_RESET;
                    host_mux[s] <= HOST_MUX_RESET;
                end else if (WR_STB && hit(ADDR, s, PIN_CTRL_OFFSET)) begin
                    dat[s] <= WDATA[PIN_DATA_LSB +: 4];
                    dir[s] <= WDATA[PIN_DIR_LSB +: 4];
                    timer_sel[s] <= WDATA[TIMER_SEL_BIT];
                    host_mux[s] <= WDATA[HOST_MUX_BIT];
                end
            end

            // ==================================================
            // Feed the multiplexer
            assign pm.dir = dir[s];
            assign pm.dat = dat[s];
            assign pm.timer_sel = timer_sel[s];
            assign pm.host_mux = host_mux[s];
            assign pm.port_mode = PORT_MODE_SELECT;
            assign pm.timer_out = TIMER_OUT[s];
            assign pm.io_access = IO_SPACE_ACCESS[s];

            pin_mux u_mux (
                .pm(pm.mux)
            );

            // ==================================================
            // Registered pin drive
            // Pin 3 in memory mode is a bus strobe and so floats
            // with the float control like the other strobes.
            always_ff @(posedge CORE_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    GPIO_OUT[4*s +: 4] <= 4'h0;
                    GPIO_OE[4*s +: 4] <= 4'h0;
                end else begin
                    GPIO_OUT[4*s +: 4] <= pm.drive_val;
                    GPIO_OE[4*s +: 3] <= pm.drive_en[2:0];
                    GPIO_OE[4*s+3] <= pm.drive_en[3] &&
                        !(PORT_MODE_SELECT && !OFF_N);
                end
            end

            // ==================================================
            // Flag pin drive
            always_ff @(posedge CORE_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    EXTERNAL_FLAG_OUT[s] <= FLAG_RESET;
                    EXTERNAL_FLAG_OE[s] <= 1'b0;
                end else begin
                    EXTERNAL_FLAG_OUT[s] <= flag[s];
                    EXTERNAL_FLAG_OE[s] <= OFF_N;
                end
            end

            // ==================================================
            // Branch test input
            // As an output the pin reports its own latched value,
            // which keeps the test well defined.
            always_ff @(posedge CORE_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    BRANCH_CONDITION_INPUT[s] <= 1'b1;
                end else if (!dir[s][2]) begin
                    BRANCH_CONDITION_INPUT[s] <= level[2];
                end else begin
                    BRANCH_CONDITION_INPUT[s] <= dat[s][2];
                end
            end

            // ==================================================
            // ROM enable strap
            // Caught once on the first edge after reset release;
            // pin 0 is an input then, so the board owns its level.
            always_ff @(posedge CORE_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    ROM_ENABLE_STRAP[s] <= 1'b0;
                end else if (!strap_taken) begin
                    ROM_ENABLE_STRAP[s] <=
                        PORT_MODE_SELECT && level[0];
                end
            end

            // ==================================================
            // Readable pin view: live level for inputs
            always_comb begin
                for (int n = 0; n < 4; n++) begin
                    if (dir[s][n]) begin
                        pin_view[n] = dat[s][n];
                    end else begin
                        pin_view[n] = level[n];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // One-shot strap window
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            strap_taken <= 1'b0;
        end else begin
            strap_taken <= 1'b1;
        end
    end

    // Pin view gathered from each subsystem for the read mux
    logic [3:0] view_all [SUBS];
    for (genvar v = 0; v < SUBS; v++) begin : g_view_tap
        assign view_all[v] = g_sub[v].pin_view;
    end

    // ==========================================================
    // Read decode
    // Unmapped words read as zero; the port never stalls.
    always_comb begin
        next_rdata = READ_IDLE;
        for (int i = 0; i < SUBS; i++) begin
            if (hit(ADDR, i, FLAG_OFFSET)) begin
                next_rdata[0] = flag[i];
            end else if (hit(ADDR, i, PIN_CTRL_OFFSET)) begin
                next_rdata[PIN_DATA_LSB +: 4] =
                    view_all[i];
                next_rdata[PIN_DIR_LSB +: 4] = dir[i];
                next_rdata[TIMER_SEL_BIT] = timer_sel[i];
                next_rdata[HOST_MUX_BIT] = host_mux[i];
            end else if (hit(ADDR, i, STATUS_OFFSET)) begin
                next_rdata[STRAP_BIT] = ROM_ENABLE_STRAP[i];
                next_rdata[PORT_MODE_BIT] = PORT_MODE_SELECT;
                next_rdata[BRANCH_BIT] = BRANCH_CONDITION_INPUT[i];
            end
        end
    end

    // ==========================================================
    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= READ_IDLE;
        end else if (RD_STB) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= READ_IDLE;
        end
    end

endmodule // gpio_flag_pins

// File: core/pin_mux.sv
// Combinational drive selection for the four pins of one subsystem.
// Assumes the caller registers the result before it reaches a pin.
`timescale 1ns/1ps
module pin_mux
    import gpio_flag_pkg::*;
(
    // Settings in, drive out
    pin_mux_if.mux pm
);

    // ==========================================================
    // Pins 0 to 2 plain; pin 3: memory-mode strobe wins, then host mode float, then timer,
    // then general use. One process owns both vectors, so no bit of
    // them has a second driver.
    always_comb begin
        pm.drive_val[2:0] = pm.dat[2:0];
        pm.drive_en[2:0] = pm.dir[2:0];
        if (pm.port_mode) begin
            // Strobe is active low during I/O space accesses
            pm.drive_val[3] = ~pm.io_access;
            pm.drive_en[3] = 1'b1;
        end else if (pm.host_mux) begin
            // Non-multiplexed host mode leaves the pin undriven
            pm.drive_val[3] = 1'b0;
            pm.drive_en[3] = 1'b0;
        end else if (pm.timer_sel) begin
            pm.drive_val[3] = pm.timer_out;
            pm.drive_en[3] = 1'b1;
        end else begin
            pm.drive_val[3] = pm.dat[3];
            pm.drive_en[3] = pm.dir[3];
        end
    end
endmodule // pin_mux

// File: shared/gpio_flag_pkg.sv
// Constants for the dual-subsystem flag and general-purpose pin block.
// Assumes a word-addressed register port with byte addresses in steps of 4.
package gpio_flag_pkg;

    // ==========================================================
    // Geometry
    localparam int SUBSYS_COUNT = 2;
    localparam int PINS_PER_SUB = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ==========================================================
    // Register map, one block of words per subsystem
    localparam logic [7:0] SUB_STRIDE = 8'h20;
    localparam logic [4:0] FLAG_OFFSET = 5'h00;
    localparam logic [4:0] FLAG_SET_OFFSET = 5'h04;
    localparam logic [4:0] FLAG_CLEAR_OFFSET = 5'h08;
    localparam logic [4:0] PIN_CTRL_OFFSET = 5'h0C;
    localparam logic [4:0] STATUS_OFFSET = 5'h10;

    // ==========================================================
    // Field positions in the pin control register
    localparam int PIN_DATA_LSB = 0;
    localparam int PIN_DIR_LSB = 4;
    localparam int TIMER_SEL_BIT = 8;
    localparam int HOST_MUX_BIT = 9;

    // Field positions in the status register
    localparam int STRAP_BIT = 0;
    localparam int PORT_MODE_BIT = 1;
    localparam int BRANCH_BIT = 2;

    // ==========================================================
    // Reset values
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [3:0] PIN_DATA_RESET = 4'h0;
    localparam logic [3:0] PIN_DIR_RESET = 4'h0;
    localparam logic TIMER_SEL_RESET = 1'b0;
    localparam logic HOST_MUX_RESET = 1'b0;
    localparam logic [31:0] READ_IDLE = 32'h0000_0000;

endpackage

// File: shared/pin_mux_if.sv
// Carrier between the register side and the pin multiplexer of one
// subsystem. Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface pin_mux_if;
    // Software settings
    logic [3:0] dir;
    logic [3:0] dat;
    logic timer_sel;
    logic host_mux;
    // Board and core inputs
    logic port_mode;
    logic timer_out;
    logic io_access;
    // Resolved pin drive
    logic [3:0] drive_val;
    logic [3:0] drive_en;

    modport ctrl (
        output dir, dat, timer_sel, host_mux,
        output port_mode, timer_out, io_access,
        input drive_val, drive_en
    );
    modport mux (
        input dir, dat, timer_sel, host_mux,
        input port_mode, timer_out, io_access,
        output drive_val, drive_en
    );
endinterface // pin_mux_if

// File: test/board_model.sv
// Board side of the pins: pad levels and the port mode strap.
// Assumes the bench sets the board's own levels and mode.
`timescale 1ns/1ps
module board_model (
    // Pads from the block
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // Board settings
    input wire logic [7:0] board_level,
    input wire logic memory_mode,
    // Toward the block
    output logic [7:0] pin_in,
    output logic port_mode
);
    // A pad shows the block's drive while enabled, else the board level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
    // Low picks host mode, high memory mode
    assign port_mode = memory_mode;
endmodule // board_model

// File: test/gpio_flag_pins_checker.sv
// Assertions on the flag and pin block, subsystem A side.
// Assumes subsystem A registers at base 0x00 and one core clock.
`timescale 1ns/1ps
module gpio_flag_pins_checker
    import gpio_flag_pkg::*;
#(
    parameter int SUBS = SUBSYS_COUNT
) (
    // Clock, reset and writes
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR_STB,
    // Board and core inputs
    input wire logic OFF_N,
    input wire logic PORT_MODE_SELECT,
    input wire logic [SUBS-1:0] TIMER_OUT,
    input wire logic [SUBS-1:0] IO_SPACE_ACCESS,
    input wire logic [4*SUBS-1:0] GPIO_IN,
    // Block outputs
    input wire logic [SUBS-1:0] EXTERNAL_FLAG_OUT,
    input wire logic [SUBS-1:0] EXTERNAL_FLAG_OE,
    input wire logic [4*SUBS-1:0] GPIO_OUT,
    input wire logic [4*SUBS-1:0] GPIO_OE,
    input wire logic [SUBS-1:0] BRANCH_CONDITION_INPUT,
    input wire logic [SUBS-1:0] ROM_ENABLE_STRAP
);
    // ======================================================
    // Shadow of the pin control word, so pin roles are known
    logic [9:0] ctl;
    logic set_wr;
    assign set_wr = WR_STB && ADDR == 8'h04 && WDATA[0];
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl <= 10'h000;
        end else if (WR_STB && ADDR == 8'h0C) begin
            ctl <= WDATA[9:0];
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // ======================================================
    // Properties, pins answer one edge after an input and two after a register write
    property p_flag_oe;
        1'b1 |=> EXTERNAL_FLAG_OE == {SUBS{$past(OFF_N)}};
    endproperty
    property p_flag_set;
        set_wr ##1 !WR_STB |=> EXTERNAL_FLAG_OUT[0];
    endproperty
    property p_pin_dir;
        (WR_STB && ADDR == 8'h0C) ##1 !WR_STB
            |=> GPIO_OE[2:0] == $past(WDATA[6:4], 2);
    endproperty
    property p_pin_out;
        (WR_STB && ADDR == 8'h0C) ##1 !WR_STB |=> (GPIO_OUT[2:0]
            & GPIO_OE[2:0]) == ($past(WDATA[2:0], 2) & GPIO_OE[2:0]);
    endproperty
    property p_pin3_ctrl;
        !PORT_MODE_SELECT && ctl[9:8] == 2'h0 |=> GPIO_OE[3] ==
            $past(ctl[7]) && (!GPIO_OE[3] || GPIO_OUT[3] == $past(ctl[3]));
    endproperty
    property p_pin3_timer;
        !PORT_MODE_SELECT && ctl[9:8] == 2'h1
            |=> GPIO_OE[3] && GPIO_OUT[3] == $past(TIMER_OUT[0]);
    endproperty
    property p_pin3_strobe;
        PORT_MODE_SELECT |=> GPIO_OE[3] == $past(OFF_N) && (!GPIO_OE[3]
            || GPIO_OUT[3] == !$past(IO_SPACE_ACCESS[0]));
    endproperty
    property p_branch;
        !ctl[6] |=> BRANCH_CONDITION_INPUT[0] == $past(GPIO_IN[2]);
    endproperty
    property p_strap;
        $rose(RESET_N) |=> ROM_ENABLE_STRAP[0] ==
            ($past(PORT_MODE_SELECT) && $past(GPIO_IN[0]));
    endproperty
    // ======================================================
    // Assertions
    a_flag_oe: assert property (p_flag_oe)
        else $error("flag enable wrong");
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set");
    a_pin_dir: assert property (p_pin_dir)
        else $error("pin direction wrong");
    a_pin_out: assert property (p_pin_out)
        else $error("pin drive wrong");
    a_pin3_ctrl: assert property (p_pin3_ctrl)
        else $error("pin 3 ignores control word");
    a_pin3_timer: assert property (p_pin3_timer)
        else $error("pin 3 timer drive wrong");
    a_pin3_strobe: assert property (p_pin3_strobe)
        else $error("pin 3 strobe wrong");
    a_branch: assert property (p_branch)
        else $error("branch input wrong");
    a_strap: assert property (p_strap)
        else $error("strap wrong");
    // Main scenarios reached
    c_set: cover property (set_wr);
    c_timer: cover property (ctl[8] && TIMER_OUT[0]);
    c_strobe: cover property (PORT_MODE_SELECT && IO_SPACE_ACCESS[0]);
endmodule // gpio_flag_pins_checker

bind gpio_flag_pins gpio_flag_pins_checker #(.SUBS(SUBS)) u_checker (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .OFF_N(OFF_N), .PORT_MODE_SELECT(PORT_MODE_SELECT),
    .TIMER_OUT(TIMER_OUT), .IO_SPACE_ACCESS(IO_SPACE_ACCESS),
    .GPIO_IN(GPIO_IN), .EXTERNAL_FLAG_OUT(EXTERNAL_FLAG_OUT),
    .EXTERNAL_FLAG_OE(EXTERNAL_FLAG_OE), .GPIO_OUT(GPIO_OUT),
    .GPIO_OE(GPIO_OE), .BRANCH_CONDITION_INPUT(BRANCH_CONDITION_INPUT),
    .ROM_ENABLE_STRAP(ROM_ENABLE_STRAP)
);

// File: test/gpio_flag_pins_tb_top.sv
// Self-checking bench for the flag and general-purpose pin block.
// Assumes subsystem A at base 0x00, B at 0x20, board modelled apart.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module gpio_flag_pins_tb_top;
    import gpio_flag_pkg::*;
    // ======================================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic off_n = 1'b1;
    logic mode = 1'b0;
    logic [1:0] tmr = 2'h0;
    logic [1:0] io_acc = 2'h0;
    logic [7:0] level = 8'hA5;
    logic [31:0] rdata;
    logic [1:0] flag, flag_oe, brch, strap;
    logic [7:0] gin, gout, goe;
    logic port_mode;
    int fails = 0;
    int n_checks = 0;
    gpio_flag_pins uut (.CORE_CLK(clk), .RESET_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR_STB(wr), .RD_STB(rd), .RDATA(rdata),
        .OFF_N(off_n), .PORT_MODE_SELECT(port_mode), .TIMER_OUT(tmr),
        .IO_SPACE_ACCESS(io_acc), .EXTERNAL_FLAG_OUT(flag),
        .EXTERNAL_FLAG_OE(flag_oe), .GPIO_IN(gin), .GPIO_OUT(gout),
        .GPIO_OE(goe), .BRANCH_CONDITION_INPUT(brch),
        .ROM_ENABLE_STRAP(strap));
    board_model board (.pin_out(gout), .pin_oe(goe), .board_level(level),
        .memory_mode(mode), .pin_in(gin), .port_mode(port_mode));
    initial begin
        forever #2 clk = ~clk;
    end
    // ======================================================
    // Bus tasks; waiting after each change lets pins settle
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        settle();
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(nm, e, rdata)
    endtask
    task automatic end_of_test;
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ======================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        `CHK("oe_reset", 8'h00, goe)
        rd_chk("ctl_a", 8'h0C, 32'h5);
        rd_chk("ctl_b", 8'h2C, 32'hA);
        `CHK("branch", 2'h1, brch)
        wr_reg(8'h04, 32'h1);
        wr_reg(8'h20, 32'h1);
        `CHK("flag_set", 2'h3, flag)
        wr_reg(8'h08, 32'h1);
        wr_reg(8'h04, 32'h0);
        `CHK("flag_clr", 2'h2, flag)
        rd_chk("flag_b", 8'h20, 32'h1);
        @(posedge clk) off_n <= 1'b0;
        settle();
        `CHK("flag_float", 2'h0, flag_oe)
        @(posedge clk) off_n <= 1'b1;
        settle();
        `CHK("flag_drive", 2'h3, flag_oe)
        wr_reg(8'h0C, 32'h75);
        `CHK("dir", 8'h07, goe)
        `CHK("drive", 8'h05, gout & goe)
        rd_chk("ctl_mix", 8'h0C, 32'h75);
        wr_reg(8'h0C, 32'h0);
        @(posedge clk) level <= 8'hA1;
        settle();
        `CHK("branch_in", 2'h0, brch)
        @(posedge clk) level <= 8'hA5;
        wr_reg(8'h0C, 32'h100);
        @(posedge clk) tmr <= 2'h1;
        settle();
        `CHK("timer_hi", 8'h08, gout & goe)
        @(posedge clk) tmr <= 2'h0;
        settle();
        `CHK("timer_lo", 8'h08, goe & ~gout)
        wr_reg(8'h0C, 32'h300);
        `CHK("host_mux", 8'h00, goe)
        wr_reg(8'h0C, 32'h88);
        `CHK("pin3_plain", 8'h08, gout & goe)
        @(posedge clk) mode <= 1'b1;
        io_acc <= 2'h1;
        settle();
        `CHK("strobe_on", 2'h2, {goe[3], gout[3]})
        rd_chk("status", 8'h10, 32'h6);
        @(posedge clk) io_acc <= 2'h0;
        settle();
        `CHK("strobe_off", 2'h3, {goe[3], gout[3]})
        @(posedge clk) off_n <= 1'b0;
        settle();
        `CHK("strobe_float", 1'b0, goe[3])
        @(posedge clk) off_n <= 1'b1;
        wr_reg(8'h18, 32'hFF);
        rd_chk("ctl_keep", 8'h0C, 32'h8D);
        rd_chk("unmapped", 8'h14, 32'h0);
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        `CHK("strap", 2'h1, strap)
        // Memory mode still selected, so both pin 3 strobes drive
        `CHK("oe_rereset", 8'h88, goe)
        end_of_test();
    end
    // Cut a hang short; the run needs about 120 cycles
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule // gpio_flag_pins_tb_top
